// ### core/lsio_core.sv
`timescale 1ns/1ps
// How it works
// - Long chip select, then release, resets
// - Low on reset pin holds reset
// - Four-bit channel mask, high enables
// - All enabled channels take writes together
// - Five pins per channel, direction each
// - Latch always written, driven if output
// - Read: pin if input, latch if output
// - Clock mode frees pin for pulse
// - Mux needs enable and clock mode
// - Pulse 31.25 us every 13 slots
// - Polarity bit inverts output pulse
// - Pulse steers detector into two bits
// - Mask detector 15.625 us after edges
// - Loop filter restarts on input change
// - One debounce time, counters per channel
// - Second filter input chosen by mux
// - Saturating zero-to-six ground-key counter
// - Latch at six, clear at zero
// - Zero period bypasses ground-key filter
// - Clock-fail clears within 400 us
// - Eight-bit status holds filtered bits
// - Reset: 8 ms, mux off, high pulse
module lsio_core #(
   parameter int CLK_FAIL_CYCLES = lsio_pkg::CLK_FAIL_CYC
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic reset_n_pin_i,
   input wire logic host_cs_n_i,
   input wire logic host_serial_clock_i,
   input wire logic frame_sync_i,
   input wire logic slot_tick_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic [19:0] line_io_pins_i,
   output logic [19:0] line_io_pins_o,
   output logic [19:0] line_io_pins_oe_n_o,
   output logic detector_select_pulse_o,
   output logic pulse_pin_is_output_o,
   output logic clock_fail_flag_o,
   output logic soft_reset_o
);
   import lsio_pkg::*;

   localparam int NP = NUM_CH * PINS_PER_CH;

   logic [3:0] ch_en_q;
   logic [NP-1:0] dir_q;
   logic [NP-1:0] latch_q;
   logic clock_from_pcm_select_q;
   logic detect_mux_enable_q;
   logic detect_pulse_polarity_q;
   logic [3:0] loop_debounce_time_field_q;
   logic [15:0] ground_key_period_field_q;
   logic clock_fail_flag_q;
   logic [31:0] fail_cnt_q;
   logic [4:0] cs_edges_q;
   logic sclk_d1_q;
   logic cs_d1_q;
   logic chip_rst_q;
   logic rst;
   logic mux_active;
   logic [3:0] slot_q;
   logic pulse_on;
   logic masked;
   logic [2:0] frame_cnt_q;
   logic ms_tick;
   logic fs_d1_q;
   logic frame_tick;
   logic [3:0] gk_ms_q [NUM_CH];
   logic [3:0] loop_pin_bit_q;
   logic [3:0] ground_key_mux_bit_q;
   logic [3:0] loop_last_q;
   logic [3:0] loop_cnt_q [NUM_CH];
   logic [3:0] filtered_loop_status_q;
   logic [2:0] gk_cnt_q [NUM_CH];
   logic [3:0] gk_latch_q;
   logic [3:0] filtered_second_status;
   logic [NP-1:0] pin_read;

   // Expand channel mask to a per-pin write mask
   function automatic logic [NP-1:0] pin_mask(input logic [3:0] en);
      logic [NP-1:0] m;
      m = '0;
      for (int c = 0; c < NUM_CH; c++)
      begin
         m[c*PINS_PER_CH +: PINS_PER_CH] = {PINS_PER_CH{en[c]}};
      end
      return m;
   endfunction

   // Combined reset: core, pin and long chip select
   assign rst = reset_i | ~reset_n_pin_i | chip_rst_q;
   assign soft_reset_o = chip_rst_q;

   // Count serial clock edges during a select; fire on release
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cs_edges_q <= 5'h00;
         sclk_d1_q <= 1'b0;
         cs_d1_q <= 1'b1;
         chip_rst_q <= 1'b0;
      end
      else
      begin
         sclk_d1_q <= host_serial_clock_i;
         cs_d1_q <= host_cs_n_i;
         chip_rst_q <= 1'b0;
         if (host_cs_n_i)
         begin
            cs_edges_q <= 5'h00;
            if (!cs_d1_q && cs_edges_q >= 5'(RESET_EDGES))
               chip_rst_q <= 1'b1;
         end
         else if (host_serial_clock_i && !sclk_d1_q &&
                  cs_edges_q != 5'h1F)
            cs_edges_q <= cs_edges_q + 5'h01;
      end
   end

   // Host-writable configuration
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ch_en_q <= CH_ENABLE_RST;
         dir_q <= '0;
         latch_q <= '0;
         clock_from_pcm_select_q <= 1'b1;
         detect_mux_enable_q <= 1'b0;
         detect_pulse_polarity_q <= 1'b0;
         loop_debounce_time_field_q <= LOOP_DEBOUNCE_RST;
         ground_key_period_field_q <= {4{GK_PERIOD_RST}};
      end
      else if (rst)
      begin
         ch_en_q <= CH_ENABLE_RST;
         dir_q <= '0; // Pins come up as inputs
         latch_q <= '0;
         clock_from_pcm_select_q <= 1'b1;
         detect_mux_enable_q <= 1'b0;
         detect_pulse_polarity_q <= 1'b0;
         loop_debounce_time_field_q <= LOOP_DEBOUNCE_RST;
         ground_key_period_field_q <= {4{GK_PERIOD_RST}};
      end
      else if (wr_i)
      begin
         case (addr_i)
            ADDR_CH_ENABLE: ch_en_q <= wdata_i[3:0];
            ADDR_PIN_DIR: dir_q <= (dir_q & ~pin_mask(ch_en_q)) |
               (wdata_i[NP-1:0] & pin_mask(ch_en_q));
            ADDR_PIN_LATCH: latch_q <= (latch_q & ~pin_mask(ch_en_q)) |
               (wdata_i[NP-1:0] & pin_mask(ch_en_q));
            ADDR_CLOCK_MODE:
               clock_from_pcm_select_q <= wdata_i[CLOCK_FROM_PCM_BIT];
            ADDR_DETECT_CFG:
            begin
               detect_mux_enable_q <= wdata_i[MUX_ENABLE_BIT];
               detect_pulse_polarity_q <= wdata_i[MUX_POLARITY_BIT];
               loop_debounce_time_field_q <= wdata_i[3:0];
            end
            ADDR_GK_PERIOD:
               for (int c = 0; c < NUM_CH; c++)
               begin
                  if (ch_en_q[c])
                     ground_key_period_field_q[c*4 +: 4] <=
                        wdata_i[c*4 +: 4];
               end
            default: ;
         endcase
      end
   end

   // Clock-fail flag drops a fixed time after a clock-mode write
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         clock_fail_flag_q <= 1'b1;
         fail_cnt_q <= '0;
      end
      else if (rst || (wr_i && addr_i == ADDR_CLOCK_MODE))
      begin
         clock_fail_flag_q <= 1'b1;
         fail_cnt_q <= '0;
      end
      else if (clock_fail_flag_q)
      begin
         if (fail_cnt_q >= 32'(CLK_FAIL_CYCLES - 1))
            clock_fail_flag_q <= 1'b0;
         else
            fail_cnt_q <= fail_cnt_q + 32'h1;
      end
   end
   assign clock_fail_flag_o = clock_fail_flag_q;

   // Pin drive; output enable is active low
   assign line_io_pins_o = latch_q;
   assign line_io_pins_oe_n_o = ~dir_q;
   assign pin_read = (dir_q & latch_q) | (~dir_q & line_io_pins_i);

   // Detector select sequencer on 64 kHz slot ticks
   assign mux_active = detect_mux_enable_q & clock_from_pcm_select_q;
   assign pulse_pin_is_output_o = clock_from_pcm_select_q;
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         slot_q <= 4'h0;
      else if (rst || !mux_active)
         slot_q <= 4'h0;
      else if (slot_tick_i)
         slot_q <= (slot_q == 4'(PULSE_PERIOD_SLOTS - 1)) ?
            4'h0 : slot_q + 4'h1;
   end
   assign pulse_on = mux_active && slot_q < 4'(PULSE_ON_SLOTS);
   // Slot right after each pulse edge is masked; detector is still settling
   assign masked = mux_active && (slot_q < 4'(MASK_SLOTS) ||
      (slot_q >= 4'(PULSE_ON_SLOTS) &&
      slot_q < 4'(PULSE_ON_SLOTS + MASK_SLOTS)));
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         detector_select_pulse_o <= 1'b0;
      else
         detector_select_pulse_o <= pulse_on ^ detect_pulse_polarity_q;
   end

   // Frame sync edge and 1 ms tick from eight frames
   assign frame_tick = frame_sync_i & ~fs_d1_q;
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         fs_d1_q <= 1'b0;
         frame_cnt_q <= 3'h0;
      end
      else
      begin
         fs_d1_q <= frame_sync_i;
         if (frame_tick)
            frame_cnt_q <= frame_cnt_q + 3'h1;
      end
   end
   assign ms_tick = frame_tick && frame_cnt_q == 3'(FRAMES_PER_MS - 1);

   // Per-channel filters
   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_ch
      logic line_detector_output;
      logic gk_in;
      logic gk_tick;
      assign line_detector_output = line_io_pins_i[c*PINS_PER_CH];
      assign gk_in = mux_active ? ground_key_mux_bit_q[c] :
         pin_read[c*PINS_PER_CH + 1];
      assign gk_tick = ms_tick &&
         gk_ms_q[c] >= ground_key_period_field_q[c*4 +: 4] - 4'h1;

      // Detector demultiplex latches
      always_ff @(posedge core_clk_i or posedge reset_i)
      begin
         if (reset_i)
         begin
            loop_pin_bit_q[c] <= 1'b0;
            ground_key_mux_bit_q[c] <= 1'b0;
         end
         else if (!mux_active)
            loop_pin_bit_q[c] <= line_detector_output;
         else if (!masked)
         begin
            if (pulse_on)
               ground_key_mux_bit_q[c] <= line_detector_output;
            else
               loop_pin_bit_q[c] <= line_detector_output;
         end
      end

      // Loop debounce, shared time, own counter
      always_ff @(posedge core_clk_i or posedge reset_i)
      begin
         if (reset_i)
         begin
            loop_last_q[c] <= 1'b0;
            loop_cnt_q[c] <= 4'h0;
            filtered_loop_status_q[c] <= 1'b0;
         end
         else if (frame_tick)
         begin
            loop_last_q[c] <= loop_pin_bit_q[c];
            if (loop_pin_bit_q[c] != loop_last_q[c])
               loop_cnt_q[c] <= 4'h0;
            else if (loop_cnt_q[c] >= loop_debounce_time_field_q)
               filtered_loop_status_q[c] <= loop_last_q[c];
            else if (ms_tick)
               loop_cnt_q[c] <= loop_cnt_q[c] + 4'h1;
         end
      end

      // Ground-key duty-cycle counter
      always_ff @(posedge core_clk_i or posedge reset_i)
      begin
         if (reset_i)
         begin
            gk_ms_q[c] <= 4'h0;
            gk_cnt_q[c] <= 3'h0;
            gk_latch_q[c] <= 1'b0;
         end
         else if (gk_tick)
         begin
            gk_ms_q[c] <= 4'h0;
            if (gk_in && gk_cnt_q[c] != 3'(GK_COUNT_MAX))
               gk_cnt_q[c] <= gk_cnt_q[c] + 3'h1;
            else if (!gk_in && gk_cnt_q[c] != 3'h0)
               gk_cnt_q[c] <= gk_cnt_q[c] - 3'h1;
            if (gk_cnt_q[c] == 3'(GK_COUNT_MAX - 1) && gk_in)
               gk_latch_q[c] <= 1'b1;
            else if (gk_cnt_q[c] == 3'h1 && !gk_in)
               gk_latch_q[c] <= 1'b0;
         end
         else if (ms_tick)
            gk_ms_q[c] <= gk_ms_q[c] + 4'h1;
      end
      assign filtered_second_status[c] =
         (ground_key_period_field_q[c*4 +: 4] == 4'h0) ?
         gk_in : gk_latch_q[c];
   end

   // Register read, data the cycle after the strobe
   always_ff @(posedge core_clk_i or posedge reset_i)
   begin
      if (reset_i)
         rdata_o <= 32'h0;
      else if (rd_i)
         case (addr_i)
            ADDR_CH_ENABLE: rdata_o <= {28'h0, ch_en_q};
            ADDR_PIN_DIR: rdata_o <= {12'h0, dir_q};
            ADDR_PIN_LATCH: rdata_o <= {12'h0, latch_q};
            ADDR_PIN_READ: rdata_o <= {12'h0, pin_read};
            ADDR_CLOCK_MODE: rdata_o <= {27'h0, clock_from_pcm_select_q,
               3'h0, clock_fail_flag_q};
            ADDR_DETECT_CFG: rdata_o <= {24'h0, detect_mux_enable_q,
               detect_pulse_polarity_q, 2'h0, loop_debounce_time_field_q};
            ADDR_GK_PERIOD: rdata_o <= {16'h0, ground_key_period_field_q};
            ADDR_RT_STATUS: rdata_o <= {24'h0, filtered_second_status,
               filtered_loop_status_q};
            default: rdata_o <= 32'h0;
         endcase
      else
         rdata_o <= 32'h0;
   end

   // Output pin follows latch only when direction is output
   a_pin_drive: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      line_io_pins_oe_n_o == ~dir_q) else $error("pin enable wrong");
   // Polarity of the previous cycle: the pulse flop lags the config flop
   a_mux_gate: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      !clock_from_pcm_select_q |=>
      detector_select_pulse_o == $past(detect_pulse_polarity_q))
      else $error("pulse without clock mode");
   a_slot_wrap: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      slot_q <= 4'(PULSE_PERIOD_SLOTS - 1)) else $error("slot overrun");
   a_gk_range: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      gk_cnt_q[0] <= 3'(GK_COUNT_MAX)) else $error("gk count high");
   a_read_data: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      rd_i && addr_i == ADDR_CH_ENABLE |=> rdata_o[3:0] == $past(ch_en_q))
      else $error("enable readback");
   a_cs_reset: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      chip_rst_q |=> ch_en_q == CH_ENABLE_RST) else $error("cs reset");
   a_pin_reset: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      !reset_n_pin_i |=> !detect_mux_enable_q &&
      loop_debounce_time_field_q == LOOP_DEBOUNCE_RST)
      else $error("pin reset");
   a_fail_set: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      wr_i && addr_i == ADDR_CLOCK_MODE |=> clock_fail_flag_o)
      else $error("fail flag");
endmodule // lsio_core

// ### core/lsio_pkg.sv
package lsio_pkg;
   // Channel and pin geometry
   localparam int NUM_CH = 4;
   localparam int PINS_PER_CH = 5;
   // Clock rate
   localparam int CLK_MHZ = 200;
   // Register byte offsets
   localparam logic [7:0] ADDR_CH_ENABLE = 8'h00;
   localparam logic [7:0] ADDR_PIN_DIR = 8'h04;
   localparam logic [7:0] ADDR_PIN_LATCH = 8'h08;
   localparam logic [7:0] ADDR_PIN_READ = 8'h0C;
   localparam logic [7:0] ADDR_CLOCK_MODE = 8'h10;
   localparam logic [7:0] ADDR_DETECT_CFG = 8'h14;
   localparam logic [7:0] ADDR_GK_PERIOD = 8'h18;
   localparam logic [7:0] ADDR_RT_STATUS = 8'h1C;
   // Field positions
   localparam int CLOCK_FROM_PCM_BIT = 4;
   localparam int MUX_POLARITY_BIT = 6;
   localparam int MUX_ENABLE_BIT = 7;
   localparam int CLOCK_FAIL_BIT = 0;
   // Reset values
   localparam logic [3:0] CH_ENABLE_RST = 4'hF;
   localparam logic [3:0] LOOP_DEBOUNCE_RST = 4'h8;
   localparam logic [3:0] GK_PERIOD_RST = 4'h0;
   // Detector select, filter, soft-reset and clock-fail timing
   localparam int PULSE_PERIOD_SLOTS = 13;
   localparam int PULSE_ON_SLOTS = 2;
   localparam int MASK_SLOTS = 1;
   localparam int FRAMES_PER_MS = 8;
   localparam int GK_COUNT_MAX = 6;
   localparam int RESET_EDGES = 16;
   localparam int CLK_FAIL_US = 400;
   localparam int CLK_FAIL_CYC = CLK_FAIL_US * CLK_MHZ;
endpackage

// ### verification/lsio_line_model.sv
`timescale 1ns/1ps
// Four line circuits: detector steered by the select pulse
module lsio_line_model (
   input wire logic clk_i,
   input wire logic pulse_i,
   input wire logic pol_i,
   input wire logic [3:0] loop_i,
   input wire logic [3:0] gk_i,
   input wire logic [3:0] second_i,
   input wire logic [11:0] aux_i,
   input wire logic [19:0] dut_o_i,
   input wire logic [19:0] dut_oe_n_i,
   output logic [19:0] pins_o
);
   logic act_q = 1'b0;
   logic [1:0] settle_q = 2'h0;
   logic [19:0] line_lvl;

   // Detector output is unsettled for two cycles after each switch
   always_ff @(posedge clk_i)
   begin
      act_q <= pulse_i ^ pol_i;
      if ((pulse_i ^ pol_i) != act_q)
      begin
         settle_q <= 2'h2;
      end
      else if (settle_q != 2'h0)
      begin
         settle_q <= settle_q - 2'h1;
      end
   end

   // Unsettled detector shows the wrong level, not the last one
   always_comb
   begin
      for (int c = 0; c < 4; c++)
      begin
         line_lvl[c*5] = (act_q ? gk_i[c] : loop_i[c]) ^ (settle_q != 2'h0);
         line_lvl[c*5+1] = second_i[c];
         line_lvl[c*5+2 +: 3] = aux_i[c*3 +: 3];
      end
   end

   // Wire level: the design wins where its enable is low
   assign pins_o = (dut_oe_n_i & line_lvl) | (~dut_oe_n_i & dut_o_i);
endmodule // lsio_line_model

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
   import lsio_pkg::*;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic rst_pin_n = 1'b1;
   logic cs_n = 1'b1;
   logic sclk = 1'b0;
   logic fs = 1'b0;
   logic slot = 1'b0;
   logic fs_run = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [19:0] pins_in, pins_out, pins_oe_n;
   logic pulse, pin_out_en, fail, soft_rst, pv;
   logic pol = 1'b0;
   logic [3:0] loop = 4'h0, gk = 4'h0, second = 4'h0;
   logic [11:0] aux = 12'h5B3;
   logic [4:0] tick_cnt = 5'h0;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   int nt;

   // Single device on the host port
   lsio_core #(.CLK_FAIL_CYCLES(20)) lsio_core_inst (
      .core_clk_i(core_clk_i), .reset_i(reset_i),
      .reset_n_pin_i(rst_pin_n), .host_cs_n_i(cs_n),
      .host_serial_clock_i(sclk), .frame_sync_i(fs), .slot_tick_i(slot),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .line_io_pins_i(pins_in),
      .line_io_pins_o(pins_out), .line_io_pins_oe_n_o(pins_oe_n),
      .detector_select_pulse_o(pulse), .pulse_pin_is_output_o(pin_out_en),
      .clock_fail_flag_o(fail), .soft_reset_o(soft_rst));

   lsio_line_model lsio_line_model_inst (
      .clk_i(core_clk_i), .pulse_i(pulse), .pol_i(pol), .loop_i(loop),
      .gk_i(gk), .second_i(second), .aux_i(aux), .dut_o_i(pins_out),
      .dut_oe_n_i(pins_oe_n), .pins_o(pins_in));

   initial
   begin
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   // Slot every 4 cycles, frame every 8 slots: 1 ms is 256 cycles
   always @(posedge core_clk_i)
   begin
      tick_cnt <= tick_cnt + 5'h1;
      slot <= (tick_cnt[1:0] == 2'h3);
      fs <= fs_run & ~tick_cnt[4];
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         $display("MISMATCH %0t run too long", $time);
         miscompares = miscompares + 1;
         test_done();
      end
   end

   task automatic test_done();
      if (miscompares == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run = tests_run + 1;
      if (g !== e)
      begin
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
         miscompares = miscompares + 1;
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   // Active width must be 2 slots and repeat every 13 slots
   task automatic measure(input logic act);
      int t0, t1, t2;
      logic pr;
      // Skip the first period: its opening slot may be cut short
      idle(60);
      t0 = -1;
      t1 = -1;
      t2 = -1;
      pr = pulse;
      for (int i = 0; i < 200; i++)
      begin
         @(posedge core_clk_i);
         if (pulse === act && pr !== act)
         begin
            t2 = (t0 >= 0 && t2 < 0) ? i : t2;
            t0 = (t0 < 0) ? i : t0;
         end
         if (pulse !== act && pr === act && t0 >= 0 && t1 < 0)
            t1 = i;
         pr = pulse;
      end
      chk(32'(t1 - t0), 32'd8);
      chk(32'(t2 - t0), 32'd52);
   endtask

   // Serial clock only runs while the chip select is low
   task automatic long_cs(input int n);
      @(posedge core_clk_i);
      cs_n <= 1'b0;
      repeat (n)
      begin
         idle(2);
         sclk <= 1'b1;
         idle(2);
         sclk <= 1'b0;
      end
      idle(2);
      cs_n <= 1'b1;
   endtask

   task automatic soft_seen(input logic e);
      logic s;
      s = 1'b0;
      repeat (10)
      begin
         @(posedge core_clk_i);
         s = s | soft_rst;
      end
      chk({31'h0, s}, {31'h0, e});
   endtask

   initial
   begin
      idle(12);
      reset_i <= 1'b0;
      rd_chk(ADDR_CH_ENABLE, 32'hF);
      rd_chk(ADDR_DETECT_CFG, 32'h08);
      rd_chk(ADDR_CLOCK_MODE, 32'h11);
      rd_chk(ADDR_GK_PERIOD, 32'h0);
      rd_chk(ADDR_RT_STATUS, 32'h0);
      rd_chk(8'h20, 32'h0);
      chk({31'h0, pin_out_en}, 32'h1);
      wr_reg(ADDR_CLOCK_MODE, 32'h10);
      #1;
      chk({31'h0, fail}, 32'h1);
      idle(25);
      rd_chk(ADDR_CLOCK_MODE, 32'h10);
      // Latch under a partial mask, then outputs on two channels
      wr_reg(ADDR_CH_ENABLE, 32'h5);
      rd_chk(ADDR_CH_ENABLE, 32'h5);
      wr_reg(ADDR_PIN_LATCH, 32'hFFFFF);
      wr_reg(ADDR_CH_ENABLE, 32'hF);
      wr_reg(ADDR_PIN_DIR, 32'hFFC00);
      idle(2);
      chk({12'h0, pins_oe_n}, 32'h003FF);
      chk({12'h0, pins_out & 20'hFFC00}, 32'h07C00);
      rd_chk(ADDR_PIN_READ, 32'h07F0C);
      wr_reg(ADDR_PIN_DIR, 32'h0);
      // Loop filter: steady input passes, chattering input does not
      wr_reg(ADDR_DETECT_CFG, 32'h02);
      loop[0] <= 1'b1;
      for (int i = 0; i < 20; i++)
      begin
         idle(64);
         loop[2] <= ~loop[2];
         if (i == 2)
            rd_chk(ADDR_RT_STATUS, 32'h0);
      end
      rd_chk(ADDR_RT_STATUS, 32'h1);
      fs_run <= 1'b0;
      loop[3] <= 1'b1;
      idle(1500);
      rd_chk(ADDR_RT_STATUS, 32'h1);
      fs_run <= 1'b1;
      idle(1500);
      rd_chk(ADDR_RT_STATUS, 32'h9);
      second[0] <= 1'b1;
      idle(20);
      rd_chk(ADDR_RT_STATUS, 32'h19);
      // Ground-key counter with a 1 ms sampling period on channel 1
      wr_reg(ADDR_GK_PERIOD, 32'h10);
      rd_chk(ADDR_GK_PERIOD, 32'h10);
      second[1] <= 1'b1;
      idle(1100);
      rd_chk(ADDR_RT_STATUS, 32'h19);
      idle(1900);
      rd_chk(ADDR_RT_STATUS, 32'h39);
      second[1] <= 1'b0;
      idle(1100);
      rd_chk(ADDR_RT_STATUS, 32'h39);
      idle(500);
      rd_chk(ADDR_RT_STATUS, 32'h19);
      // Multiplex: clock mode already set before the enable
      wr_reg(ADDR_GK_PERIOD, 32'h0);
      gk[2] <= 1'b1;
      second[3] <= 1'b1;
      wr_reg(ADDR_DETECT_CFG, 32'h82);
      measure(1'b1);
      idle(2000);
      rd_chk(ADDR_RT_STATUS, 32'h49);
      pol <= 1'b1;
      wr_reg(ADDR_DETECT_CFG, 32'hC2);
      measure(1'b0);
      idle(1000);
      rd_chk(ADDR_RT_STATUS, 32'h49);
      wr_reg(ADDR_CLOCK_MODE, 32'h0);
      idle(4);
      chk({31'h0, pin_out_en}, 32'h0);
      pv = pulse;
      nt = 0;
      repeat (120)
      begin
         @(posedge core_clk_i);
         nt = nt + ((pulse !== pv) ? 1 : 0);
         pv = pulse;
      end
      chk(32'(nt), 32'h0);
      // Reset pin, then short and long chip select
      wr_reg(ADDR_CH_ENABLE, 32'h3);
      idle(1);
      rst_pin_n <= 1'b0;
      idle(6);
      rst_pin_n <= 1'b1;
      rd_chk(ADDR_CH_ENABLE, 32'hF);
      rd_chk(ADDR_DETECT_CFG, 32'h08);
      wr_reg(ADDR_CH_ENABLE, 32'h3);
      long_cs(15);
      soft_seen(1'b0);
      rd_chk(ADDR_CH_ENABLE, 32'h3);
      long_cs(16);
      soft_seen(1'b1);
      rd_chk(ADDR_CH_ENABLE, 32'hF);
      test_done();
   end
endmodule // tb
